// *** tb_top.sv ***
// Self-checking bench for the window watchdog driven over its register bus.
`timescale 1ns/1ns
`default_nettype none
`include "wwd_map.svh"
module tb_top;
  localparam logic [11:0] AC = `WWD_OFF_CTRL;
  localparam logic [11:0] AF = `WWD_OFF_CFG;
  localparam logic [11:0] AS = `WWD_OFF_STAT;
  logic        pclk, tb_rstn, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        debug_halt, debug_freeze_control, sys_reset_req, irq, far_rst_n, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, v0;
  logic [3:0]  pstrb;
  int          pulses, error_cnt, checks_done, n, ep, i;
  int          cyc = 0;

  assign presetn = tb_rstn & far_rst_n;

  wwd_top #(.PRESCALE(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
    .debug_freeze_control(debug_freeze_control), .sys_reset_req(sys_reset_req),
    .early_warning_irq(irq)
  );
  wwd_far i_far (.pclk(pclk), .sys_reset_req(sys_reset_req), .rst_n(far_rst_n),
                 .pulses(pulses));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // The whole run needs a few thousand cycles; the ceiling leaves a wide margin.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                     input logic [31:0] g);
    checks_done++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      error_cnt++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", nm, lo, hi, g);
    end
  endtask : rng

  // An idle edge comes first, so back-to-back calls never drive a signal twice at once.
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xf

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xf(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  task automatic resets(input int k);
    ep = ep + k;
    repeat (12) @(posedge pclk);
    chk("reset pulses", 32'(ep), 32'(pulses));
  endtask : resets

  initial begin
    {tb_rstn, psel, penable, pwrite, debug_halt, debug_freeze_control} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    error_cnt = 0;
    checks_done = 0;
    ep = 0;
    repeat (12) @(posedge pclk);
    tb_rstn <= 1'b1;
    rd(AC);
    chk("ctrl", 32'h7f, rv);
    chk("ready", 32'h1, 32'(pready));
    rd(AF);
    chk("cfg", 32'h7f, rv);
    rd(AS);
    chk("stat", 32'h0, rv);
    rd(12'h00c);
    chk("unmapped err", 32'h1, 32'(er));
    xf(1'b1, AF, 32'h0, 4'h1);
    chk("byte err", 32'h1, 32'(er));
    for (i = 0; i < 4; i++) begin
      xf(1'b1, AF, 32'h7f | (32'(i) << 7), 4'h3);
      chk("half err", 32'h0, 32'(er));
      rd(AC);
      v0 = rv;
      repeat (64 << i) @(posedge pclk);
      rd(AC);
      rng("ticks", 3, 5, v0 - rv);
    end
    wr(AF, 32'h27f);
    wr(AF, 32'h7f);
    rd(AF);
    chk("enable kept", 32'h27f, rv);
    debug_halt <= 1'b1;
    debug_freeze_control <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(AC);
    v0 = rv;
    repeat (100) @(posedge pclk);
    rd(AC);
    chk("frozen", v0, rv);
    debug_freeze_control <= 1'b0;
    repeat (100) @(posedge pclk);
    rd(AC);
    rng("halt run", 5, 8, v0 - rv);
    debug_halt <= 1'b0;
    wr(AC, 32'h7f);
    rd(AC);
    rng("refresh", 32'h7d, 32'h7f, rv);
    repeat (1100) @(posedge pclk);
    chk("irq idle", 32'h0, 32'(irq));
    wr(AS, 32'h1);
    rd(AS);
    chk("flag", 32'h1, rv);
    wr(AS, 32'h0);
    rd(AS);
    chk("flag clr", 32'h0, rv);
    wr(AC, 32'hc3);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    rd(AC);
    chk("warn cnt", 32'hc0, rv);
    while (pulses == 0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    rng("timeout", 45, 70, 32'(n));
    resets(1);
    rd(AC);
    chk("ctrl again", 32'h7f, rv);
    chk("irq reset", 32'h0, 32'(irq));
    wr(AC, 32'hff);
    wr(AC, 32'h7f);
    rd(AC);
    chk("active kept", 32'h1, 32'(rv[7]));
    resets(0);
    wr(AF, 32'h50);
    wr(AC, 32'hff);
    resets(1);
    wr(AC, 32'hbf);
    resets(1);
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// *** wwd_far.sv ***
// Reset controller model that answers a reset request by pulling the system reset low.
`timescale 1ns/1ns
`default_nettype none
module wwd_far (
  input  wire logic pclk,
  input  wire logic sys_reset_req,
  output logic      rst_n,
  output int        pulses
);
  int hold = 0;
  initial begin
    rst_n  = 1'b1;
    pulses = 0;
  end
  // Each request cycle counts once, so a stretched pulse shows up as extra resets.
  always @(posedge pclk) begin
    if (sys_reset_req === 1'b1) begin
      pulses <= pulses + 1;
      hold   <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
    rst_n <= !(sys_reset_req === 1'b1 || hold > 1);
  end
endmodule : wwd_far
`default_nettype wire

// *** wwd_map.svh ***
// Register map, field positions, reset values and timing constants of the window watchdog.
// Operation
// - Reset when activated and counter decrements from 0x40 to 0x3F.
// - Reset when activated and refresh written while counter exceeds window limit.
// - Disabled after reset; activation bit cannot be cleared by writes.
// - Counter decrements every tick whether or not activated.
// - Counter is a 7-bit read/write field in the control register.
// - Write setting activation with top bit clear causes immediate reset.
// - Early-warning interrupt raised when counter reaches 0x40 and enabled.
// - Early-warning interrupt needs both enable and activation bit set.
// - Writing zero to the early-warning flag clears the interrupt.
// - Tick is bus clock divided by 4096 then by two to select.
// - Timeout equals tick period times lower six counter bits plus one.
// - Counter writes do not restart the prescaler.
// - Debug freeze input stops the counter while processor is halted.
// - Registers accept half-word and word accesses only.
// - Time-base select codes 00..11 divide by 1, 2, 4, 8.
// - Flag sets at 0x40 even if interrupt disabled; writing one ignored.
// - Early-warning enable, once set, cannot be cleared by software.
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH
`define WWD_OFF_CTRL      12'h000
`define WWD_OFF_CFG       12'h004
`define WWD_OFF_STAT      12'h008
`define WWD_CTRL_RESET    8'h7f
`define WWD_CFG_RESET     10'h07f
`define WWD_CNT_WARN      7'h40
`define WWD_CNT_TOP       6
`define WWD_ACT_BIT       7
`define WWD_EWE_BIT       9
`define WWD_TB_LSB        7
`define WWD_PRESCALE      4096
`define WWD_PRE_W         12
`define WWD_TB_W          3
`endif

// *** wwd_pkg.sv ***
// Types shared by the window watchdog modules.
package wwd_pkg;
  typedef logic [6:0] wwd_cnt_t;
  typedef logic [1:0] wwd_tb_t;
  typedef enum logic [1:0] {
    WWD_RST_IDLE  = 2'b00,
    WWD_RST_PULSE = 2'b01
  } wwd_rst_state_t;
endpackage : wwd_pkg

// *** wwd_sync.sv ***
// Two-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "wwd_map.svh"
module wwd_sync
  import wwd_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : wwd_sync
`default_nettype wire

// *** wwd_tick.sv ***
// Prescaler producing the counter tick: fixed divide then power-of-two time base.
`timescale 1ns/1ns
`default_nettype none
`include "wwd_map.svh"
module wwd_tick
  import wwd_pkg::*;
#(
  parameter int PRESCALE = `WWD_PRESCALE
) (
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    ce,
  input  wire logic    run,
  input  wire wwd_tb_t tb_sel,
  output logic         tick
);
  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PMAX = PW'(PRESCALE - 1);
  logic [PW-1:0]         pre_q;
  logic [`WWD_TB_W-1:0]  tb_q;
  logic                  pre_wrap;
  logic [`WWD_TB_W-1:0]  tb_mask;
  assign pre_wrap = (pre_q == PMAX);
  assign tb_mask  = `WWD_TB_W'((4'h1 << tb_sel) - 4'h1);
  // The prescaler is never reloaded by a counter write, so refresh timing jitters by a tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (ce && run) begin
      pre_q <= pre_wrap ? '0 : pre_q + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_q <= '0;
    end else if (ce && run && pre_wrap) begin
      tb_q <= ((tb_q & tb_mask) == tb_mask) ? '0 : tb_q + 1'b1;
    end
  end
  assign tick = ce && run && pre_wrap && ((tb_q & tb_mask) == tb_mask);
endmodule : wwd_tick
`default_nettype wire

// *** wwd_top.sv ***
// Window watchdog with APB register slave, reset request and early-warning interrupt.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "wwd_map.svh"
module wwd_top
  import wwd_pkg::*;
#(
  parameter int PRESCALE = `WWD_PRESCALE
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debug_halt,
  input  wire logic        debug_freeze_control,
  output logic             sys_reset_req,
  output logic             early_warning_irq
);
  wwd_cnt_t       cnt_q;
  logic           activation_bit_q;
  logic           early_warning_enable_q;
  wwd_tb_t        time_base_select_q;
  wwd_cnt_t       window_q;
  logic           early_warning_flag_q;
  wwd_rst_state_t rst_state_q;
  logic           halt_s;
  logic           frz_s;
  logic           tick;
  logic           access;
  logic           wr;
  logic           lo_ok;
  logic           hi_ok;
  logic           size_ok;
  logic           wr_ctrl;
  logic           wr_cfg;
  logic           wr_stat;
  logic           mapped;
  logic           late_rst;
  logic           early_rst;
  logic           soft_rst;
  logic           warn_evt;
  logic           act_next;

  wwd_sync u_sync_halt (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (debug_halt),
    .q       (halt_s)
  );
  wwd_sync u_sync_frz (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (debug_freeze_control),
    .q       (frz_s)
  );
  wwd_tick #(
    .PRESCALE (PRESCALE)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (!(halt_s && frz_s)),
    .tb_sel  (time_base_select_q),
    .tick    (tick)
  );

  // Bus decode; byte writes are refused since only half-word and word lanes are legal.
  assign access  = psel && penable && ce;
  assign wr      = access && pwrite;
  assign lo_ok   = (pstrb[1:0] == 2'b11) || (pstrb[1:0] == 2'b00);
  assign hi_ok   = (pstrb[3:2] == 2'b11) || (pstrb[3:2] == 2'b00);
  assign size_ok = !pwrite || (lo_ok && hi_ok && (pstrb != 4'h0));
  assign mapped  = (paddr == `WWD_OFF_CTRL) || (paddr == `WWD_OFF_CFG) ||
                   (paddr == `WWD_OFF_STAT);
  assign wr_ctrl = wr && size_ok && pstrb[0] && (paddr == `WWD_OFF_CTRL);
  assign wr_cfg  = wr && size_ok && (paddr == `WWD_OFF_CFG);
  assign wr_stat = wr && size_ok && pstrb[0] && (paddr == `WWD_OFF_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!mapped || !size_ok);

  assign act_next  = activation_bit_q || (wr_ctrl && pwdata[`WWD_ACT_BIT]);
  assign late_rst  = activation_bit_q && tick && (cnt_q == `WWD_CNT_WARN);
  assign early_rst = activation_bit_q && wr_ctrl && (cnt_q > window_q);
  assign soft_rst  = wr_ctrl && act_next && !pwdata[`WWD_CNT_TOP];
  assign warn_evt  = tick && (cnt_q == `WWD_CNT_WARN + 7'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'(`WWD_CTRL_RESET);
    end else if (ce) begin
      if (wr_ctrl) begin
        cnt_q <= pwdata[6:0];
      end else if (tick) begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activation_bit_q <= 1'b0;
    end else if (ce) begin
      activation_bit_q <= act_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_warning_enable_q <= 1'b0;
      time_base_select_q     <= 2'b00;
      window_q               <= 7'h7f;
    end else if (wr_cfg) begin
      if (pstrb[1]) begin
        early_warning_enable_q <= early_warning_enable_q | pwdata[`WWD_EWE_BIT];
        time_base_select_q[1]  <= pwdata[`WWD_TB_LSB+1];
      end
      if (pstrb[0]) begin
        time_base_select_q[0] <= pwdata[`WWD_TB_LSB];
        window_q              <= pwdata[6:0];
      end
    end
  end

  // The set wins over a same-cycle clear so a warning is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_warning_flag_q <= 1'b0;
    end else if (ce) begin
      if (warn_evt) begin
        early_warning_flag_q <= 1'b1;
      end else if (wr_stat && !pwdata[0]) begin
        early_warning_flag_q <= 1'b0;
      end
    end
  end

  assign early_warning_irq = early_warning_flag_q && early_warning_enable_q &&
                             activation_bit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_state_q   <= WWD_RST_IDLE;
      sys_reset_req <= 1'b0;
    end else if (ce) begin
      unique case (rst_state_q)
        WWD_RST_IDLE: begin
          if (late_rst || early_rst || soft_rst) begin
            rst_state_q   <= WWD_RST_PULSE;
            sys_reset_req <= 1'b1;
          end
        end
        WWD_RST_PULSE: begin
          rst_state_q   <= WWD_RST_IDLE;
          sys_reset_req <= 1'b0;
        end
        default: begin
          rst_state_q   <= WWD_RST_IDLE;
          sys_reset_req <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      unique case (paddr)
        `WWD_OFF_CTRL: prdata <= {24'h000000, activation_bit_q, cnt_q};
        `WWD_OFF_CFG:  prdata <= {22'h0, early_warning_enable_q, time_base_select_q,
                                  window_q};
        `WWD_OFF_STAT: prdata <= {31'h0, early_warning_flag_q};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  a_late_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && activation_bit_q && tick && cnt_q == 7'h40 && rst_state_q == WWD_RST_IDLE)
      |=> sys_reset_req
  ) else $error("late reset missing");

  a_early_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && activation_bit_q && wr_ctrl && cnt_q > window_q && rst_state_q == WWD_RST_IDLE)
      |=> sys_reset_req
  ) else $error("early refresh reset missing");

  a_window_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && wr_ctrl && cnt_q == window_q && pwdata[6] && !late_rst && !tick &&
     rst_state_q == WWD_RST_IDLE) |=> !sys_reset_req
  ) else $error("limit refresh reset");

  a_act_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    activation_bit_q |=> activation_bit_q
  ) else $error("activation cleared");

  a_ewe_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    early_warning_enable_q |=> early_warning_enable_q
  ) else $error("enable cleared");

  a_cnt_dec: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && tick && !wr_ctrl) |=> cnt_q == $past(cnt_q) - 7'h01
  ) else $error("no decrement");

  a_soft_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (soft_rst && rst_state_q == WWD_RST_IDLE) |=> sys_reset_req
  ) else $error("soft reset missing");

  a_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && tick && !wr_ctrl && cnt_q == 7'h41) |=> early_warning_flag_q && cnt_q == 7'h40
  ) else $error("flag not set at warning");

  a_irq_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    early_warning_irq |-> (early_warning_enable_q && activation_bit_q)
  ) else $error("irq without enables");

  a_rst_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(sys_reset_req) |=> (!ce || !sys_reset_req)
  ) else $error("reset pulse too long");

  a_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && wr_stat && !pwdata[0] && !warn_evt) |=> !early_warning_flag_q
  ) else $error("flag not cleared");

  a_ready_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> pready
  ) else $error("ready low in access");

  a_size_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !size_ok) |-> pslverr
  ) else $error("bad strobes accepted");

  a_byte_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && psel && penable && pwrite && !size_ok) |=> window_q == $past(window_q)
  ) else $error("byte write took effect");

  a_cnt_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!tick && !wr_ctrl) |=> cnt_q == $past(cnt_q)
  ) else $error("counter moved without tick");

  a_cnt_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> cnt_q == $past(pwdata[6:0])
  ) else $error("counter write lost");

  a_frozen_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    (halt_s && frz_s) |-> !tick
  ) else $error("tick while frozen");

  a_quiet_disabled: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rst_state_q == WWD_RST_IDLE && !act_next) |=> !sys_reset_req
  ) else $error("reset while disabled");

  a_irq_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    early_warning_irq |-> early_warning_flag_q
  ) else $error("irq without flag");

  a_irq_raise: assert property (
    @(posedge pclk) disable iff (!presetn)
    (early_warning_flag_q && early_warning_enable_q && activation_bit_q) |-> early_warning_irq
  ) else $error("irq not raised");

  a_flag_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && wr_stat && pwdata[0] && early_warning_flag_q) |=> early_warning_flag_q
  ) else $error("writing one cleared flag");

  a_flag_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (early_warning_flag_q && !(wr_stat && !pwdata[0])) |=> early_warning_flag_q
  ) else $error("flag dropped");

  a_ewe_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_cfg && pstrb[1] && pwdata[`WWD_EWE_BIT]) |=> early_warning_enable_q
  ) else $error("enable write lost");

  a_act_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[`WWD_ACT_BIT]) |=> activation_bit_q
  ) else $error("activation write lost");

  a_tick_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick
  ) else $error("tick too wide");

  a_pulse_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sys_reset_req && ce) |=> !sys_reset_req
  ) else $error("reset pulse stretched");

  a_pulse_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sys_reset_req && !ce) |=> sys_reset_req
  ) else $error("reset pulse lost while frozen");

  a_state_match: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> (sys_reset_req == (rst_state_q == WWD_RST_PULSE))
  ) else $error("reset state mismatch");

  a_cnt_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && !wr_ctrl && cnt_q == 7'h00) |=> cnt_q == 7'h7f
  ) else $error("counter wrap wrong");

  a_warn_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(early_warning_flag_q) |-> $past(cnt_q) == 7'h41
  ) else $error("flag set off warning");

  a_unmapped_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable && !pwrite && !mapped) |=> prdata == 32'h0000_0000
  ) else $error("unmapped read not zero");

  a_ctrl_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable && !pwrite && paddr == `WWD_OFF_CTRL)
      |=> prdata == {24'h0, $past(activation_bit_q), $past(cnt_q)}
  ) else $error("control read wrong");

  a_tb_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_cfg |=> time_base_select_q == $past(time_base_select_q)
  ) else $error("time base changed");
endmodule : wwd_top
`default_nettype wire
